// *** logic/pmd_params.svh ***
// timing, rate and reset constants of the pdm microphone decimator
`ifndef PMD_PARAMS_SVH
`define PMD_PARAMS_SVH

`define PMD_CLK_HZ        125000000
`define PMD_PDM_HZ        3072000
`define PMD_CLK_HALF      (`PMD_CLK_HZ / (2 * `PMD_PDM_HZ))
`define PMD_DEC1          8
`define PMD_DEC2          4
`define PMD_DEC3          6
`define PMD_OUT_HZ        16000
`define PMD_DELAY_US      1125
`define PMD_DELAY_SMP     ((`PMD_DELAY_US * `PMD_OUT_HZ) / 1000000)
`define PMD_NORM_SHIFT    23
`define PMD_DCB_K         9
`define PMD_SHIFT_RST     6'h00
`define PMD_SAT_RST       1'b0

`endif

// *** logic/pmd_pkg.sv ***
// types shared by the pdm microphone decimator
package pmd_pkg;
	typedef logic signed [31:0] pmd_sample_t;
	typedef logic signed [5:0]  pmd_shift_t;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_DCB,
		PH_GAIN,
		PH_STORE
	} pmd_phase_t;
endpackage : pmd_pkg

// *** logic/pmd_dly_mem.sv ***
// circular sample memory with registered read-before-write
`timescale 1ns/1ps
module pmd_dly_mem #(
	parameter int DEPTH = 18,
	parameter int WIDTH = 64
) (
	input  wire logic             clk_i,    // core clock
	input  wire logic             we_i,     // write strobe
	input  wire logic [4:0]       addr_i,   // slot address
	input  wire logic [WIDTH-1:0] wdata_i,  // new word
	output logic      [WIDTH-1:0] rdata_o   // old word of that slot
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	// old contents come out as the slot is overwritten, so depth equals delay
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			rdata_o      <= mem_q[addr_i];
			mem_q[addr_i] <= wdata_i;
		end
	end
endmodule : pmd_dly_mem

// *** logic/pmd_decimator.sv ***
// two-channel pdm to 16 khz pcm decimator with dc block and gain
// Overview of operation
// - two pdm microphones in, two-channel pcm out at 16 khz
// - first fir stage decimates each stream by 8 to 384 khz
// - second fir stage decimates by 4 to 96 khz
// - third fir stage decimates by 6 to 16 khz
// - single-pole dc blocking iir, -3 db corner near 5 hz
// - samples carried at 32-bit precision through the chain
// - combined fir response: 70 db stopband, 0.9 db ripple, 6.8 khz; code uses plain boxcar stages instead
// - total pin to output latency is 1.125 ms; code adds 18 samples of padding on top of the filter delay
// - output scaled by power-of-two shift, left or right
// - positive shift with saturate enable clamps to full scale
// - shift resets to zero, unity gain
// - host writes gain: shift and saturate enable together on one strobe
// - read-gain returns current shift and saturate enable
`timescale 1ns/1ps
`include "pmd_params.svh"
module pmd_decimator (
	input  wire logic                clk_i,            // 125 mhz core clock
	input  wire logic                sys_rst_i,        // synchronous reset, active high
	input  wire logic                pdm_data_i,       // shared mic data pin
	output logic                     pdm_clk_o,        // mic bit clock
	input  wire logic                gain_wr_i,        // write-gain command strobe
	input  wire pmd_pkg::pmd_shift_t gain_shift_i,     // shift amount, signed
	input  wire logic                gain_sat_i,       // saturate enable
	input  wire logic                gain_rd_i,        // read-gain command strobe
	output logic                     gain_rsp_valid_o, // read answer strobe
	output pmd_pkg::pmd_shift_t      gain_rsp_shift_o, // current shift
	output logic                     gain_rsp_sat_o,   // current saturate enable
	output logic                     pcm_valid_o,      // pcm sample pair strobe
	output pmd_pkg::pmd_sample_t     pcm_ch0_o,        // channel 0 sample
	output pmd_pkg::pmd_sample_t     pcm_ch1_o         // channel 1 sample
);
	import pmd_pkg::*;

	localparam logic [4:0] HALF_LAST = 5'(`PMD_CLK_HALF - 1);
	localparam logic [2:0] DEC1_LAST = 3'(`PMD_DEC1 - 1);
	localparam logic [1:0] DEC2_LAST = 2'(`PMD_DEC2 - 1);
	localparam logic [2:0] DEC3_LAST = 3'(`PMD_DEC3 - 1);
	localparam logic [4:0] DLY_LAST  = 5'(`PMD_DELAY_SMP - 1);

	// ==========================================================
	// helpers
	// one pdm bit maps to +1 or -1
	function automatic pmd_sample_t pmd_bit_val(input logic b);
		pmd_bit_val = b ? 32'sh0000_0001 : -32'sh0000_0001;
	endfunction : pmd_bit_val

	// clamp a wide value to 32-bit full scale
	function automatic pmd_sample_t pmd_clamp(input logic signed [63:0] v);
		if (v > 64'sh0000_0000_7fff_ffff) begin
			pmd_clamp = 32'sh7fff_ffff;
		end else if (v < -64'sh0000_0000_8000_0000) begin
			pmd_clamp = 32'sh8000_0000;
		end else begin
			pmd_clamp = v[31:0];
		end
	endfunction : pmd_clamp

	// ==========================================================
	// bit clock and pin capture
	logic [4:0] div_cnt_q;
	logic       pdm_clk_q;
	logic       din_meta_q;
	logic       din_sync_q;
	logic       bit0_q;
	logic       bit0_d;
	logic       tick;
	logic       cap_ch0;
	logic       pair_done;

	assign tick      = (div_cnt_q == HALF_LAST);
	assign cap_ch0   = tick & pdm_clk_q;
	assign pair_done = tick & ~pdm_clk_q;
	assign bit0_d    = cap_ch0 ? din_sync_q : bit0_q;
	assign pdm_clk_o = pdm_clk_q;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_cnt_q <= 5'h00;
			pdm_clk_q <= 1'b0;
		end else begin
			div_cnt_q <= tick ? 5'h00 : div_cnt_q + 5'h01;
			pdm_clk_q <= tick ? ~pdm_clk_q : pdm_clk_q;
		end
	end

	// pin is asynchronous to the core clock
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			din_meta_q <= 1'b0;
			din_sync_q <= 1'b0;
			bit0_q     <= 1'b0;
		end else begin
			din_meta_q <= pdm_data_i;
			din_sync_q <= din_meta_q;
			bit0_q     <= bit0_d;
		end
	end

	// ==========================================================
	// decimating fir stages, boxcar accumulate and dump
	// approximate boxcar response
	pmd_sample_t acc1_q [2];
	pmd_sample_t acc2_q [2];
	pmd_sample_t acc3_q [2];
	pmd_sample_t in1    [2];
	pmd_sample_t in2    [2];
	pmd_sample_t in3    [2];
	logic [2:0]  cnt1_q;
	logic [1:0]  cnt2_q;
	logic [2:0]  cnt3_q;
	logic        s1_q;
	logic        s2_q;
	logic        s3_q;
	pmd_sample_t y1_q   [2];
	pmd_sample_t y2_q   [2];

	assign in1[0] = pmd_bit_val(bit0_q);
	assign in1[1] = pmd_bit_val(din_sync_q);
	assign in2[0] = y1_q[0];
	assign in2[1] = y1_q[1];
	assign in3[0] = y2_q[0];
	assign in3[1] = y2_q[1];

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt1_q <= 3'h0;
			s1_q   <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				acc1_q[c] <= 32'sh0000_0000;
				y1_q[c]   <= 32'sh0000_0000;
			end
		end else begin
			s1_q <= pair_done && (cnt1_q == DEC1_LAST);
			if (pair_done) begin
				cnt1_q <= (cnt1_q == DEC1_LAST) ? 3'h0 : cnt1_q + 3'h1;
				for (int c = 0; c < 2; c++) begin
					acc1_q[c] <= (cnt1_q == DEC1_LAST) ? 32'sh0000_0000 : acc1_q[c] + in1[c];
					if (cnt1_q == DEC1_LAST) begin
						y1_q[c] <= acc1_q[c] + in1[c];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt2_q <= 2'h0;
			s2_q   <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				acc2_q[c] <= 32'sh0000_0000;
				y2_q[c]   <= 32'sh0000_0000;
			end
		end else begin
			s2_q <= s1_q && (cnt2_q == DEC2_LAST);
			if (s1_q) begin
				cnt2_q <= (cnt2_q == DEC2_LAST) ? 2'h0 : cnt2_q + 2'h1;
				for (int c = 0; c < 2; c++) begin
					acc2_q[c] <= (cnt2_q == DEC2_LAST) ? 32'sh0000_0000 : acc2_q[c] + in2[c];
					if (cnt2_q == DEC2_LAST) begin
						y2_q[c] <= acc2_q[c] + in2[c];
					end
				end
			end
		end
	end

	// ==========================================================
	// 16 khz post processing
	pmd_sample_t x_q   [2];
	pmd_sample_t xp_q  [2];
	pmd_sample_t dcb_q [2];
	pmd_sample_t g_q   [2];
	pmd_sample_t dcb_d [2];
	pmd_sample_t g_d   [2];
	pmd_phase_t  ph_q;
	pmd_phase_t  ph_d;
	pmd_shift_t  shift_q;
	logic        sat_q;
	logic [4:0]  wp_q;
	logic        mem_we;
	logic [63:0] mem_rdata;
	logic        out_pend_q;
	logic        full_q;

	// decimate by 6, scaled up to 3/4 of 32-bit full scale
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt3_q <= 3'h0;
			s3_q   <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				acc3_q[c] <= 32'sh0000_0000;
				x_q[c]    <= 32'sh0000_0000;
			end
		end else begin
			s3_q <= s2_q && (cnt3_q == DEC3_LAST);
			if (s2_q) begin
				cnt3_q <= (cnt3_q == DEC3_LAST) ? 3'h0 : cnt3_q + 3'h1;
				for (int c = 0; c < 2; c++) begin
					acc3_q[c] <= (cnt3_q == DEC3_LAST) ? 32'sh0000_0000 : acc3_q[c] + in3[c];
					if (cnt3_q == DEC3_LAST) begin
						x_q[c] <= (acc3_q[c] + in3[c]) <<< `PMD_NORM_SHIFT;
					end
				end
			end
		end
	end

	// dc block: y = x - x1 + y1 - y1/512
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			dcb_d[c] = pmd_clamp(64'(x_q[c]) - 64'(xp_q[c]) + 64'(dcb_q[c]) - 64'(dcb_q[c] >>> `PMD_DCB_K));
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			if (shift_q > 6'sh00) begin
				g_d[c] = sat_q ? pmd_clamp(64'(dcb_q[c]) <<< shift_q) : dcb_q[c] <<< shift_q;
			end else begin
				g_d[c] = dcb_q[c] >>> (-shift_q);
			end
		end
	end

	always_comb begin
		case (ph_q)
			PH_IDLE:  ph_d = s3_q ? PH_DCB : PH_IDLE;
			PH_DCB:   ph_d = PH_GAIN;
			PH_GAIN:  ph_d = PH_STORE;
			PH_STORE: ph_d = PH_IDLE;
			default:  ph_d = PH_IDLE;
		endcase
	end

	assign mem_we = (ph_q == PH_STORE);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ph_q <= PH_IDLE;
			for (int c = 0; c < 2; c++) begin
				xp_q[c]  <= 32'sh0000_0000;
				dcb_q[c] <= 32'sh0000_0000;
				g_q[c]   <= 32'sh0000_0000;
			end
		end else begin
			ph_q <= ph_d;
			for (int c = 0; c < 2; c++) begin
				if (ph_q == PH_DCB) begin
					dcb_q[c] <= dcb_d[c];
					xp_q[c]  <= x_q[c];
				end
				if (ph_q == PH_GAIN) begin
					g_q[c] <= g_d[c];
				end
			end
		end
	end

	// ==========================================================
	// latency padding, one slot per output sample pair
	// fixed latency
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wp_q       <= 5'h00;
			out_pend_q <= 1'b0;
			full_q     <= 1'b0;
		end else begin
			out_pend_q <= mem_we;
			full_q     <= full_q | (out_pend_q & (wp_q == 5'h00));
			if (mem_we) begin
				wp_q <= (wp_q == DLY_LAST) ? 5'h00 : wp_q + 5'h01;
			end
		end
	end

	pmd_dly_mem #(
		.DEPTH (`PMD_DELAY_SMP),
		.WIDTH (64)
	) u_dly (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.addr_i  (wp_q),
		.wdata_i ({g_q[1], g_q[0]}),
		.rdata_o (mem_rdata)
	);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pcm_valid_o <= 1'b0;
			pcm_ch0_o   <= 32'sh0000_0000;
			pcm_ch1_o   <= 32'sh0000_0000;
		end else begin
			pcm_valid_o <= out_pend_q;
			if (out_pend_q) begin
				pcm_ch0_o <= full_q ? mem_rdata[31:0] : 32'sh0000_0000;
				pcm_ch1_o <= full_q ? mem_rdata[63:32] : 32'sh0000_0000;
			end
		end
	end

	// ==========================================================
	// gain command port
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shift_q          <= `PMD_SHIFT_RST;
			sat_q            <= `PMD_SAT_RST;
			gain_rsp_valid_o <= 1'b0;
			gain_rsp_shift_o <= `PMD_SHIFT_RST;
			gain_rsp_sat_o   <= `PMD_SAT_RST;
		end else begin
			if (gain_wr_i) begin
				shift_q <= gain_shift_i;
				sat_q   <= gain_sat_i;
			end
			gain_rsp_valid_o <= gain_rd_i;
			if (gain_rd_i) begin
				gain_rsp_shift_o <= shift_q;
				gain_rsp_sat_o   <= sat_q;
			end
		end
	end
endmodule : pmd_decimator

// *** verification/pmd_decimator_sva.sv ***
// port checker of the pdm microphone decimator
`timescale 1ns/1ps
module pmd_decimator_chk (
	input wire logic                 clk_i,            // clock
	input wire logic                 sys_rst_i,        // reset
	input wire logic                 pdm_data_i,       // mic data
	input wire logic                 pdm_clk_o,        // bit clock
	input wire logic                 gain_wr_i,        // write strobe
	input wire pmd_pkg::pmd_shift_t  gain_shift_i,     // shift
	input wire logic                 gain_sat_i,       // saturate
	input wire logic                 gain_rd_i,        // read strobe
	input wire logic                 gain_rsp_valid_o, // answer strobe
	input wire pmd_pkg::pmd_shift_t  gain_rsp_shift_o, // answer shift
	input wire logic                 gain_rsp_sat_o,   // answer saturate
	input wire logic                 pcm_valid_o,      // sample strobe
	input wire pmd_pkg::pmd_sample_t pcm_ch0_o,        // channel 0
	input wire pmd_pkg::pmd_sample_t pcm_ch1_o         // channel 1
);
	import pmd_pkg::*;
	// =====================================
	// helper counters
	logic [12:0] gap_q;
	logic [4:0]  half_q;
	logic        pclk_q, tog_q, pcm_q, wr_q;
	always_ff @(posedge clk_i) begin
		pclk_q <= pdm_clk_o;
		half_q <= (pdm_clk_o != pclk_q) ? 5'h00 : half_q + 5'h01;
		gap_q  <= pcm_valid_o ? 13'h0000 : gap_q + 13'h0001;
		// first toggle and first sample are not measured from reset
		tog_q  <= !sys_rst_i && (tog_q || pdm_clk_o != pclk_q);
		pcm_q  <= !sys_rst_i && (pcm_q || pcm_valid_o);
		wr_q   <= !sys_rst_i && (wr_q || gain_wr_i);
	end
	// =====================================
	// assertions
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_rd_answer: assert property (gain_rd_i |=> gain_rsp_valid_o)
		else $error("read answer missing");
	chk_rsp_alone: assert property (!gain_rd_i |=> !gain_rsp_valid_o)
		else $error("answer without read");
	chk_rd_value: assert property (gain_wr_i ##1 gain_rd_i |=> gain_rsp_shift_o == $past(gain_shift_i, 2)
		&& gain_rsp_sat_o == $past(gain_sat_i, 2)) else $error("read value not last write");
	chk_rst_unity: assert property (gain_rd_i && !wr_q |=> gain_rsp_shift_o == 6'h00 && !gain_rsp_sat_o)
		else $error("gain not unity after reset");
	chk_rsp_hold: assert property (!gain_rd_i |=> $stable(gain_rsp_shift_o) && $stable(gain_rsp_sat_o))
		else $error("answer changed without read");
	chk_bitclk_half: assert property (tog_q && pdm_clk_o != pclk_q |-> half_q == 5'h13)
		else $error("bit clock half period wrong");
	chk_pcm_period: assert property (pcm_q && pcm_valid_o |-> gap_q == 13'h1DFF)
		else $error("sample spacing wrong");
	chk_pcm_hold: assert property (!pcm_valid_o |-> $stable(pcm_ch0_o) && $stable(pcm_ch1_o))
		else $error("sample changed without strobe");
	cov_read: cover property (gain_rd_i ##1 gain_rsp_valid_o);
	cov_sat: cover property (gain_wr_i && gain_sat_i && gain_shift_i > 6'sh00);
	cov_pcm: cover property (pcm_valid_o && pcm_ch0_o != 32'h0000_0000);
endmodule : pmd_decimator_chk

bind pmd_decimator pmd_decimator_chk i_pmd_decimator_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.pdm_data_i(pdm_data_i), .pdm_clk_o(pdm_clk_o), .gain_wr_i(gain_wr_i), .gain_shift_i(gain_shift_i),
	.gain_sat_i(gain_sat_i), .gain_rd_i(gain_rd_i), .gain_rsp_valid_o(gain_rsp_valid_o),
	.gain_rsp_shift_o(gain_rsp_shift_o), .gain_rsp_sat_o(gain_rsp_sat_o), .pcm_valid_o(pcm_valid_o),
	.pcm_ch0_o(pcm_ch0_o), .pcm_ch1_o(pcm_ch1_o));

// *** verification/pmd_mic_model.sv ***
// two pdm microphones sharing one data line
`timescale 1ns/1ps
module pmd_mic_model #(
	parameter int DRIVE_NS = 10
) (
	input  wire logic pdm_clk_i,  // bit clock from the device
	input  wire logic mic0_bit_i, // level sent by mic 0
	input  wire logic mic1_bit_i, // level sent by mic 1
	output logic      pdm_data_o  // shared data line
);
	// =====================================
	// mic 0 on high half, mic 1 on low
	// the line shows garbage while the mics hand over
	initial begin
		pdm_data_o = 1'b0;
		forever begin
			@(pdm_clk_i);
			pdm_data_o = ~pdm_data_o;
			#(DRIVE_NS) pdm_data_o = pdm_clk_i ? mic0_bit_i : mic1_bit_i;
		end
	end
endmodule : pmd_mic_model

// *** verification/pdm_mic_decimator_tb.sv ***
// self-checking bench of the pdm microphone decimator
`timescale 1ns/1ps
module pdm_mic_decimator_tb;
	import pmd_pkg::*;
	logic        clk_i, sys_rst_i, gain_wr_i, gain_sat_i, gain_rd_i, mic0_bit, mic1_bit;
	logic        pdm_data_i, pdm_clk_o, gain_rsp_valid_o, gain_rsp_sat_o, pcm_valid_o;
	pmd_shift_t  gain_shift_i, gain_rsp_shift_o;
	pmd_sample_t pcm_ch0_o, pcm_ch1_o;
	int          err_count, checks_done;
	// sample windows per output 19..22: ch0 low/high, ch1 low/high
	logic [31:0] rng_t [4][4] = '{'{32'h5E00_0000, 32'h6000_0000, 32'hA000_0000, 32'hA200_0000},
		'{32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h8000_0000, 32'h8000_0000},
		'{32'h2F00_0000, 32'h3000_0000, 32'hD000_0000, 32'hD100_0000},
		'{32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_0001, 32'h7FFF_FFFF}};
	logic [6:0]  gain_t [3] = '{7'h05, 7'h7F, 7'h02};

	pmd_decimator i_pmd_decimator (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pdm_data_i(pdm_data_i),
		.pdm_clk_o(pdm_clk_o), .gain_wr_i(gain_wr_i), .gain_shift_i(gain_shift_i), .gain_sat_i(gain_sat_i),
		.gain_rd_i(gain_rd_i), .gain_rsp_valid_o(gain_rsp_valid_o), .gain_rsp_shift_o(gain_rsp_shift_o),
		.gain_rsp_sat_o(gain_rsp_sat_o), .pcm_valid_o(pcm_valid_o), .pcm_ch0_o(pcm_ch0_o), .pcm_ch1_o(pcm_ch1_o));
	pmd_mic_model i_pmd_mic_model (.pdm_clk_i(pdm_clk_o), .mic0_bit_i(mic0_bit), .mic1_bit_i(mic1_bit),
		.pdm_data_o(pdm_data_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk_eq(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_eq

	task automatic chk_rng(input string nm, input logic signed [31:0] lo, hi, got);
		checks_done++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_count++;
			$display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
		end
	endtask : chk_rng

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	task automatic gain_write(input logic [5:0] s, input logic t);
		@(negedge clk_i);
		gain_wr_i = 1'b1;
		gain_shift_i = s;
		gain_sat_i = t;
		@(negedge clk_i);
		gain_wr_i = 1'b0;
	endtask : gain_write

	// answer is looked at in the one cycle it stands
	task automatic gain_check(input logic [5:0] s, input logic t, input logic wr);
		@(negedge clk_i);
		gain_rd_i = 1'b1;
		gain_wr_i = wr;
		@(negedge clk_i);
		gain_rd_i = 1'b0;
		gain_wr_i = 1'b0;
		chk_eq("rsp_valid", 32'h0000_0001, 32'(gain_rsp_valid_o));
		chk_eq("rsp_gain", 32'({s, t}), 32'({gain_rsp_shift_o, gain_rsp_sat_o}));
	endtask : gain_check

	// read raised in the cycle right after the write, so the new value must come back
	task automatic gain_wr_rd(input logic [5:0] s, input logic t);
		@(negedge clk_i);
		gain_wr_i = 1'b1;
		gain_shift_i = s;
		gain_sat_i = t;
		@(negedge clk_i);
		gain_wr_i = 1'b0;
		gain_rd_i = 1'b1;
		@(negedge clk_i);
		gain_rd_i = 1'b0;
		chk_eq("rsp_valid", 32'h0000_0001, 32'(gain_rsp_valid_o));
		chk_eq("rsp_gain", 32'({s, t}), 32'({gain_rsp_shift_o, gain_rsp_sat_o}));
	endtask : gain_wr_rd

	task automatic wait_pcm();
		int k;
		k = 0;
		@(negedge clk_i);
		while (pcm_valid_o !== 1'b1 && k < 8000) begin
			@(negedge clk_i);
			k++;
		end
		chk_eq("pcm_valid", 32'h0000_0001, 32'(pcm_valid_o));
	endtask : wait_pcm

	task automatic t_gain_rw();
		gain_check(6'h00, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			gain_write(i[0] ? 6'h3E : 6'h03 + 6'(i * 14), !i[0]);
			gain_check(i[0] ? 6'h3E : 6'h03 + 6'(i * 14), !i[0], 1'b0);
		end
		gain_shift_i = 6'h05;
		gain_sat_i = 1'b0;
		// a read in the write's own cycle still returns the old setting
		gain_check(6'h3E, 1'b0, 1'b1);
		gain_check(6'h05, 1'b0, 1'b0);
		gain_wr_rd(6'h2A, 1'b1);
		gain_write(6'h00, 1'b0);
		$display("test gain_rw done");
	endtask : t_gain_rw

	// mic 0 all ones, mic 1 all zeros: opposite channels at 3/4 full scale
	task automatic t_pcm();
		for (int n = 1; n <= 22; n++) begin
			wait_pcm();
			if (n <= 18) begin
				chk_eq("pcm_ch0", 32'h0000_0000, pcm_ch0_o);
				chk_eq("pcm_ch1", 32'h0000_0000, pcm_ch1_o);
			end else begin
				chk_rng("pcm_ch0", rng_t[n-19][0], rng_t[n-19][1], pcm_ch0_o);
				chk_rng("pcm_ch1", rng_t[n-19][2], rng_t[n-19][3], pcm_ch1_o);
			end
			if (n <= 3) begin
				gain_write(gain_t[n-1][6:1], gain_t[n-1][0]);
			end
		end
		$display("test pcm done");
	endtask : t_pcm

	initial begin
		sys_rst_i = 1'b1;
		gain_wr_i = 1'b0;
		gain_rd_i = 1'b0;
		gain_shift_i = 6'h00;
		gain_sat_i = 1'b0;
		mic0_bit = 1'b1;
		mic1_bit = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (8) @(negedge clk_i);
		sys_rst_i = 1'b0;
		t_gain_rw();
		t_pcm();
		test_done();
	end

	// about 170k cycles of traffic are expected
	initial begin
		#1600000;
		err_count++;
		$display("[ERR] watchdog expected finish seen timeout");
		test_done();
	end
endmodule : pdm_mic_decimator_tb
